//--- verilog/motor_algo_debug_override_regs.v
// Debug override register bank steering speed source, loop enables and startup holds.
`timescale 1ns/1ps
`include "algo_override_map.vh"
module motor_algo_debug_override_regs (
    input wire clk_in,
    input wire rst_in,
    input wire wr_en_in,
    input wire [7:0] wr_addr_in,
    input wire [31:0] wr_data_in,
    input wire [14:0] analog_speed_in,
    input wire [1:0] startup_method_in,
    input wire spin_detect_enable_in,
    input wire [8:0] config_align_angle_in,
    input wire [8:0] forced_align_angle_in,
    output reg [14:0] speed_cmd_out,
    output reg open_loop_select_out,
    output reg hold_align_state_out,
    output reg hold_slow_cycle_state_out,
    output reg hold_position_detect_state_out,
    output reg hold_spin_detect_state_out,
    output reg [8:0] align_angle_out,
    output reg speed_regulator_off_out,
    output reg current_regulator_off_out,
    output reg signed [13:0] iq_ref_scaled_out,
    output reg [9:0] vd_ref_code_out,
    output reg [9:0] vq_ref_code_out,
    output reg [4:0] measure_select_out,
    output reg param_measure_start_out
);
    // =========================================================
    // Register storage
    // =========================================================
    reg [31:0] speed_and_startup_override_reg;
    reg [31:0] voltage_and_measurement_override_reg;
    wire wr_speed = wr_en_in && (wr_addr_in == `SPEED_STARTUP_OVR_ADDR);
    wire wr_volt = wr_en_in && (wr_addr_in == `VOLT_MEAS_OVR_ADDR);

    always @(posedge clk_in) begin
        if (rst_in) begin
            speed_and_startup_override_reg <= `OVR_RESET;
            voltage_and_measurement_override_reg <= `OVR_RESET;
        end else begin
            if (wr_speed) begin
                speed_and_startup_override_reg <= wr_data_in;
            end
            if (wr_volt) begin
                voltage_and_measurement_override_reg <= wr_data_in;
            end
        end
    end

    // =========================================================
    // Derived controls
    // =========================================================
    wire [31:0] s = speed_and_startup_override_reg;
    wire [31:0] v = voltage_and_measurement_override_reg;
    wire [9:0] iq_code = s[`IQ_REF_MSB:`IQ_REF_LSB];
    wire cur_off = v[`CUR_REG_OFF_BIT];
    // A dedicated speed-regulator-off bit is not in this bank; the current
    // regulator off bit implies it, so the torque reference follows from it.
    wire spd_off = cur_off;
    wire method_align = (startup_method_in == `STARTUP_ALIGN) ||
        (startup_method_in == `STARTUP_DOUBLE_ALIGN);
    wire [8:0] raw_angle = s[`ALIGN_SRC_BIT] ? forced_align_angle_in :
        config_align_angle_in;
    // Nine bits reach 511, so one subtraction wraps any value below 720.
    wire [8:0] wrapped_angle = (raw_angle >= `ANGLE_WRAP) ?
        (raw_angle - `ANGLE_WRAP) : raw_angle;
    // The scaled reference stays in raw code units times ten; the divide by
    // 500 is left to the consumer to avoid a divider here.
    reg signed [13:0] iq_next;
    always @* begin
        iq_next = 14'h0000;
        if (iq_code < `REF_POS_LIMIT) begin
            iq_next = $signed({4'h0, iq_code}) * $signed(`IQ_SCALE);
        end else if (iq_code > `REF_NEG_BASE) begin
            iq_next = -($signed({4'h0, iq_code - `REF_NEG_BASE}) *
                $signed(`IQ_SCALE));
        end
    end

    // =========================================================
    // Registered outputs
    // =========================================================
    always @(posedge clk_in) begin
        if (rst_in) begin
            speed_cmd_out <= 15'h0000;
            open_loop_select_out <= 1'b0;
            hold_align_state_out <= 1'b0;
            hold_slow_cycle_state_out <= 1'b0;
            hold_position_detect_state_out <= 1'b0;
            hold_spin_detect_state_out <= 1'b0;
            align_angle_out <= 9'h000;
            speed_regulator_off_out <= 1'b0;
            current_regulator_off_out <= 1'b0;
            iq_ref_scaled_out <= 14'h0000;
            vd_ref_code_out <= 10'h000;
            vq_ref_code_out <= 10'h000;
            measure_select_out <= 5'h00;
            param_measure_start_out <= 1'b0;
        end else begin
            if (s[`SPD_OVERRIDE_BIT]) begin
                speed_cmd_out <= s[`SPD_DIGITAL_MSB:`SPD_DIGITAL_LSB];
            end else begin
                speed_cmd_out <= analog_speed_in;
            end
            open_loop_select_out <= s[`OPEN_LOOP_BIT];
            hold_align_state_out <= s[`HOLD_ALIGN_BIT] && method_align;
            hold_slow_cycle_state_out <= s[`HOLD_SLOW_CYCLE_BIT] &&
                (startup_method_in == `STARTUP_SLOW_CYCLE);
            hold_position_detect_state_out <= s[`HOLD_POS_DETECT_BIT] &&
                (startup_method_in == `STARTUP_POS_DETECT);
            hold_spin_detect_state_out <= s[`HOLD_SPIN_DETECT_BIT] &&
                spin_detect_enable_in;
            align_angle_out <= wrapped_angle;
            speed_regulator_off_out <= spd_off;
            current_regulator_off_out <= cur_off;
            iq_ref_scaled_out <= spd_off ? iq_next : 14'h0000;
            vd_ref_code_out <= cur_off ? v[`VD_MSB:`VD_LSB] : 10'h000;
            vq_ref_code_out <= cur_off ? v[`VQ_MSB:`VQ_LSB] : 10'h000;
            measure_select_out <= v[`MEAS_R_BIT:`MEAS_SHADOW_BIT];
            // One pulse per write carrying the start bit; a held bit does not relaunch.
            param_measure_start_out <= wr_volt && wr_data_in[`MEAS_START_BIT];
        end
    end
endmodule // motor_algo_debug_override_regs

//--- verilog/algo_override_map.vh
// Register offsets, field positions, reset values and scaling constants of the override registers.
// Functional notes
// - Override bit 31 set selects the digital speed value as speed command.
// - Override bit clear selects the analog, PWM or frequency speed input.
// - Bits 30-16 hold the digital speed value used while override is set.
// - Bit 15 set commutates open loop; clear runs the closed loop.
// - Bit 14 holds the align state when startup is align or double align.
// - Bit 13 holds the slow-first-cycle state when that startup is chosen.
// - Bit 12 holds the position detect state when that startup is chosen.
// - Bit 11 holds the spin detect state when spin detect is enabled.
// - Bit 10 picks configured align angle (0) or forced align angle (1).
// - Bits 9-0 give torque current reference while speed regulator is off.
// - Forced align angle is a 9-bit degree value applied modulo 360.
// - Current regulator off bit disables current and speed loops.
// - Writing one to the measurement start bit launches parameter measurement.
`ifndef ALGO_OVERRIDE_MAP_VH
`define ALGO_OVERRIDE_MAP_VH
`define SPEED_STARTUP_OVR_ADDR 8'hEC
`define VOLT_MEAS_OVR_ADDR 8'hEE
`define OVR_RESET 32'h00000000
`define SPD_OVERRIDE_BIT 31
`define SPD_DIGITAL_MSB 30
`define SPD_DIGITAL_LSB 16
`define OPEN_LOOP_BIT 15
`define HOLD_ALIGN_BIT 14
`define HOLD_SLOW_CYCLE_BIT 13
`define HOLD_POS_DETECT_BIT 12
`define HOLD_SPIN_DETECT_BIT 11
`define ALIGN_SRC_BIT 10
`define IQ_REF_MSB 9
`define IQ_REF_LSB 0
`define CUR_REG_OFF_BIT 26
`define VD_MSB 25
`define VD_LSB 16
`define VQ_MSB 15
`define VQ_LSB 6
`define MEAS_START_BIT 5
`define MEAS_R_BIT 4
`define MEAS_L_BIT 3
`define MEAS_KE_BIT 2
`define MEAS_MECH_BIT 1
`define MEAS_SHADOW_BIT 0
`define REF_POS_LIMIT 10'h1F4
`define REF_NEG_BASE 10'h200
`define IQ_SCALE 14'h000A
`define ANGLE_WRAP 9'h168
`define STARTUP_ALIGN 2'h0
`define STARTUP_DOUBLE_ALIGN 2'h1
`define STARTUP_POS_DETECT 2'h2
`define STARTUP_SLOW_CYCLE 2'h3
`endif

//--- sim/override_host.sv
// Host model that writes whole words into the override registers.
`timescale 1ns/1ps
module override_host (
    input wire clk_in,
    output reg wr_en_out = 1'b0,
    output reg [7:0] wr_addr_out = 8'h00,
    output reg [31:0] wr_data_out = 32'h00000000
);
    // An idle cycle follows each write so the strobe never changes twice in one step.
    task wr(input [7:0] a, input [31:0] d);
        begin
            wr_en_out = 1'b1;
            wr_addr_out = a;
            wr_data_out = d;
            @(posedge clk_in) #1;
            wr_en_out = 1'b0;
            wr_data_out = ~d;
            @(posedge clk_in) #1;
        end
    endtask
endmodule // override_host

//--- sim/motor_algo_debug_override_regs_asserts.sv
// Concurrent checks on the override register bank ports.
`timescale 1ns/1ps
module motor_algo_debug_override_regs_asserts (
    input wire clk_in, rst_in, wr_en_in, spin_detect_enable_in,
    input wire [7:0] wr_addr_in,
    input wire [31:0] wr_data_in,
    input wire [14:0] analog_speed_in, speed_cmd_out,
    input wire [1:0] startup_method_in,
    input wire open_loop_select_out, hold_align_state_out, hold_slow_cycle_state_out,
    input wire hold_position_detect_state_out, hold_spin_detect_state_out,
    input wire speed_regulator_off_out, current_regulator_off_out, param_measure_start_out,
    input wire [8:0] config_align_angle_in, forced_align_angle_in, align_angle_out,
    input wire signed [13:0] iq_ref_scaled_out
);
    reg [31:0] s1_reg, s2_reg;
    reg [1:0] live_reg;
    wire [8:0] ang = s1_reg[10] ? forced_align_angle_in : config_align_angle_in;
    wire [9:0] c = s1_reg[9:0];
    wire [13:0] mag = c < 10'h1F4 ? c * 14'h000A : c > 10'h200 ? (c - 10'h200) * 14'h000A : 14'h0000;
    wire [13:0] iqx = !s2_reg[26] ? 14'h0000 : c > 10'h200 ? -mag : mag;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // Shadow copies let the speed, open-loop, hold, angle, regulator-off and torque outputs be judged against the word last written.
    always @(posedge clk_in) begin
        live_reg <= rst_in ? 2'h0 : {live_reg[0], 1'b1};
        s1_reg <= rst_in ? 32'h0 : (wr_en_in && wr_addr_in == 8'hEC) ? wr_data_in : s1_reg;
        s2_reg <= rst_in ? 32'h0 : (wr_en_in && wr_addr_in == 8'hEE) ? wr_data_in : s2_reg;
    end
    chk_speed_src: assert property (live_reg[1] |-> speed_cmd_out
        == $past(s1_reg[31] ? s1_reg[30:16] : analog_speed_in)) else $error("speed");
    chk_open_loop: assert property (live_reg[1] |-> open_loop_select_out
        == $past(s1_reg[15])) else $error("open loop");
    chk_hold_states: assert property (live_reg[1] |->
        {hold_align_state_out, hold_slow_cycle_state_out, hold_position_detect_state_out}
        == $past({s1_reg[14] && startup_method_in < 2'h2, s1_reg[13] && startup_method_in
        == 2'h3, s1_reg[12] && startup_method_in == 2'h2})) else $error("hold");
    chk_spin_hold: assert property (live_reg[1] |-> hold_spin_detect_state_out
        == $past(s1_reg[11] && spin_detect_enable_in)) else $error("spin hold");
    chk_align_angle: assert property (live_reg[1] |-> align_angle_out
        == $past(ang >= 9'h168 ? ang - 9'h168 : ang)) else $error("angle");
    chk_loops_off: assert property (live_reg[1] |-> current_regulator_off_out
        == $past(s2_reg[26]) && speed_regulator_off_out == $past(s2_reg[26])) else $error("loops");
    chk_iq_ref: assert property (live_reg[1] |-> iq_ref_scaled_out
        == $signed($past(iqx))) else $error("iq ref");
    chk_measure_start: assert property (wr_en_in && wr_addr_in == 8'hEE && wr_data_in[5]
        |-> ##1 param_measure_start_out) else $error("measure start");
    cover property (param_measure_start_out);
    cover property (hold_align_state_out);
    cover property (iq_ref_scaled_out < 0);
endmodule // motor_algo_debug_override_regs_asserts
bind motor_algo_debug_override_regs motor_algo_debug_override_regs_asserts i_chk (.*);

//--- sim/motor_algo_debug_override_regs_tb.sv
// Directed bench for the override register bank.
`timescale 1ns/1ps
module motor_algo_debug_override_regs_tb;
    reg clk_in = 1'b0, rst_in = 1'b1;
    reg [1:0] method = 2'h0;
    wire wr_en, ol, ha, hs, hp, hd, so, co, ms;
    wire [7:0] wr_addr;
    wire [31:0] wr_data;
    wire [14:0] speed;
    wire [8:0] angle;
    wire [9:0] vd, vq;
    wire [4:0] msel;
    // The start pulse stands for one cycle only, so it is caught here while it stands.
    reg ms_seen = 1'b0;
    always @(posedge clk_in) if (ms) ms_seen <= 1'b1;
    wire signed [13:0] iq;
    integer n_errors = 0, n_tests = 0, i;
    reg [9:0] codes [0:5] = '{10'h000, 10'h1F3, 10'h1F4, 10'h200, 10'h201, 10'h3E8};
    override_host i_host (.clk_in(clk_in), .wr_en_out(wr_en), .wr_addr_out(wr_addr),
        .wr_data_out(wr_data));
    motor_algo_debug_override_regs i_dut (.clk_in(clk_in), .rst_in(rst_in), .wr_en_in(wr_en),
        .wr_addr_in(wr_addr), .wr_data_in(wr_data), .analog_speed_in(15'h1234),
        .startup_method_in(method), .spin_detect_enable_in(1'b1), .config_align_angle_in(9'h05A),
        .forced_align_angle_in(9'h190), .speed_cmd_out(speed), .open_loop_select_out(ol),
        .hold_align_state_out(ha), .hold_slow_cycle_state_out(hs),
        .hold_position_detect_state_out(hp), .hold_spin_detect_state_out(hd),
        .align_angle_out(angle), .speed_regulator_off_out(so), .current_regulator_off_out(co),
        .iq_ref_scaled_out(iq), .vd_ref_code_out(vd), .vq_ref_code_out(vq),
        .measure_select_out(msel),
        .param_measure_start_out(ms));
    function [13:0] iq_exp(input [9:0] c);
        iq_exp = c < 10'h1F4 ? c * 14'h000A : c > 10'h200 ? 14'h0 - (c - 10'h200) * 14'h000A : 14'h0;
    endfunction
    task chk(input [31:0] g, input [31:0] e);
        begin
            n_tests = n_tests + 1;
            if (g !== e) begin
                n_errors = n_errors + 1;
                $display("mismatch at %0t: got %h expected %h", $time, g, e);
            end
        end
    endtask
    task close_out;
        begin
            if (n_errors == 0 && n_tests > 0) $display("All checks passed");
            else $display("Checks failed");
            $finish;
        end
    endtask
    always #12.5 clk_in = ~clk_in;
    initial begin
        repeat (12) @(posedge clk_in);
        #1 rst_in = 1'b0;
        chk({ol, co, ha}, 0);
        @(posedge clk_in) #1;
        chk(speed, 15'h1234);
        i_host.wr(8'hEC, 32'h8005FC00);
        chk(speed, 15'h0005);
        chk(ol, 1);
        chk(angle, 9'h028);
        for (i = 0; i < 4; i = i + 1) begin
            method = i[1:0];
            @(posedge clk_in) #1;
            chk({ha, hs, hp}, {i < 2, i == 3, i == 2});
        end
        chk(hd, 1);
        i_host.wr(8'h10, 32'h00000000);
        chk(ol, 1);
        i_host.wr(8'hEE, 32'h04000020);
        chk(ms_seen, 1);
        @(posedge clk_in) #1;
        chk({ms, so, co}, 3'h3);
        i_host.wr(8'hEE, 32'h04ABCD5F);
        chk({vd, vq, msel}, {10'h0AB, 10'h335, 5'h1F});
        for (i = 0; i < 6; i = i + 1) begin
            i_host.wr(8'hEC, {22'h0, codes[i]});
            chk({18'h0, iq}, iq_exp(codes[i]));
        end
        chk({speed, angle, hd, ha}, {15'h1234, 9'h05A, 2'h0});
        close_out;
    end
endmodule // motor_algo_debug_override_regs_tb
